/* File: core/flash_protect_bit_cmd_seq.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_protect_bit_cmd_seq #(
  parameter int AW = flash_seq_pkg::ADDR_W,
  parameter int DW = flash_seq_pkg::DATA_W,
  parameter int WORDS = 1024,
  parameter int NV_CYCLES = flash_seq_pkg::NV_OP_CYCLES,
  parameter int PROG_CYC = flash_seq_pkg::PROG_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic chipEnable_n,
  input wire logic writeEnable_n,
  input wire logic outputEnable_n,
  input wire logic syncMode,
  input wire logic [AW-1:0] addrIn,
  input wire logic [DW-1:0] dataIn,
  output logic [DW-1:0] readData_q,
  output logic address_valid_n,
  output logic [1:0] bank_q,
  output logic [7:0] sector_address_q,
  output logic nvMode,
  output logic busy
);
  //--------------------------------------------------------------------
  // command states
  //--------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_READ = 4'b0000,
    ST_UNL1 = 4'b0001,
    ST_UNL2 = 4'b0010,
    ST_NV = 4'b0011,
    ST_NVPROG = 4'b0100,
    ST_NVERASE = 4'b0101,
    ST_NVBUSY = 4'b0110,
    ST_PROGADDR = 4'b0111,
    ST_PROGBUSY = 4'b1000
  } cmd_state_e;

  cmd_state_e state_q;
  logic writeDone;
  logic [AW-1:0] wAddr;
  logic [DW-1:0] wData;
  logic readStrobe;
  logic oeDly_q;
  logic [15:0] timer_q;
  logic [5:0] sel_q;
  logic nvErase_q;
  logic [7:0] nvSector_q;
  logic secureBit_q, pwLockBit_q, persLockBit_q, sectLock_q;
  logic [flash_seq_pkg::NUM_SECTORS-1:0] sectBits_q;
  logic nvBit;
  logic [DW-1:0] mem [WORDS];
  logic [DW-1:0] progData_q;
  logic [AW-1:0] progAddr_q;

  //--------------------------------------------------------------------
  // address decode helpers
  //--------------------------------------------------------------------
  function automatic logic is_sel(input logic [5:0] a, input logic [5:0] s);
    return (a & flash_seq_pkg::SEL_MASK) == s;
  endfunction : is_sel

  function automatic logic [7:0] sector_of(input logic [AW-1:0] a);
    return a[flash_seq_pkg::SECT_HI:flash_seq_pkg::SECT_LO];
  endfunction : sector_of

  //--------------------------------------------------------------------
  // write cycle capture
  //--------------------------------------------------------------------
  bus_cycle_latch #(.AW(AW), .DW(DW)) u_latch (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .chipEnable_n(chipEnable_n),
    .writeEnable_n(writeEnable_n),
    .addrIn(addrIn),
    .dataIn(dataIn),
    .writeDone(writeDone),
    .latchAddr_q(wAddr),
    .latchData_q(wData)
  );

  //--------------------------------------------------------------------
  // read strobe: one read each time ce and oe become both low
  //--------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) oeDly_q <= 1'b0;
    else oeDly_q <= !chipEnable_n && !outputEnable_n;
  end
  assign readStrobe = !chipEnable_n && !outputEnable_n && !oeDly_q;

  //--------------------------------------------------------------------
  // status outputs
  //--------------------------------------------------------------------
  assign busy = (state_q == ST_NVBUSY) || (state_q == ST_PROGBUSY);
  assign nvMode = (state_q == ST_NV) || (state_q == ST_NVPROG)
    || (state_q == ST_NVERASE) || (state_q == ST_NVBUSY);
  // strobe held low during a bit operation (not an array program) in sync mode
  assign address_valid_n = !(syncMode && (state_q == ST_NVBUSY));

  //--------------------------------------------------------------------
  // selected non-volatile bit and read path
  //--------------------------------------------------------------------
  // lock selectors win; any other low address reads the sector bit
  always_comb begin
    nvBit = sectBits_q[nvSector_q];
    if (is_sel(sel_q, flash_seq_pkg::SEL_SECURE)) nvBit = secureBit_q;
    else if (is_sel(sel_q, flash_seq_pkg::SEL_PWLOCK)) nvBit = pwLockBit_q;
    else if (is_sel(sel_q, flash_seq_pkg::SEL_PERSLOCK)) nvBit = persLockBit_q;
  end

  read_status_mux #(.DW(DW)) u_rd (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .readStrobe(readStrobe),
    .nvMode(nvMode),
    .nvBusy(state_q == ST_NVBUSY && !syncMode),
    .nvBitValue(nvBit),
    .arrayWord(mem[addrIn[$clog2(WORDS)-1:0]]),
    .readData_q(readData_q)
  );

  //--------------------------------------------------------------------
  // bank and sector capture
  //--------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bank_q <= 2'b00;
      sector_address_q <= 8'h00;
    end else if (writeDone) begin
      bank_q <= wAddr[flash_seq_pkg::BANK_HI:flash_seq_pkg::BANK_LO];
      sector_address_q <= sector_of(wAddr);
    end
  end

  //--------------------------------------------------------------------
  // command sequencer
  //--------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_READ;
      sel_q <= 6'h00;
      nvErase_q <= 1'b0;
      nvSector_q <= 8'h00;
      progAddr_q <= '0;
      progData_q <= '0;
    end else if (writeDone && wData[7:0] == flash_seq_pkg::CODE_RESET && !busy) begin
      state_q <= ST_READ;
    end else begin
      case (state_q)
        ST_READ: begin
          if (writeDone && wData[7:0] == flash_seq_pkg::CODE_UNLOCK1
              && wAddr[10:0] == flash_seq_pkg::UNLOCK_ADDR1) state_q <= ST_UNL1;
        end
        ST_UNL1: begin
          if (writeDone) begin
            if (wData[7:0] == flash_seq_pkg::CODE_UNLOCK2
                && wAddr[10:0] == flash_seq_pkg::UNLOCK_ADDR2) state_q <= ST_UNL2;
            else state_q <= ST_READ;
          end
        end
        ST_UNL2: begin
          if (writeDone) begin
            if (wData[7:0] == flash_seq_pkg::CODE_NVMODE) state_q <= ST_NV;
            else if (wData[7:0] == flash_seq_pkg::CODE_PROGRAM) state_q <= ST_PROGADDR;
            else state_q <= ST_READ;
          end
        end
        ST_NV: begin
          if (writeDone) begin
            sel_q <= wAddr[5:0];
            nvSector_q <= sector_of(wAddr);
            // address line six deliberately ignored here
            if (wData[7:0] == flash_seq_pkg::CODE_NVPROG) state_q <= ST_NVPROG;
            else if (wData[7:0] == flash_seq_pkg::CODE_NVERASE) state_q <= ST_NVERASE;
          end
        end
        ST_NVPROG: begin
          if (writeDone) begin
            nvSector_q <= sector_of(wAddr);
            nvErase_q <= 1'b0;
            if (wData[7:0] == flash_seq_pkg::CODE_PROGCONF) state_q <= ST_NVBUSY;
            else state_q <= ST_NV;
          end
        end
        ST_NVERASE: begin
          if (writeDone) begin
            nvErase_q <= 1'b1;
            if (wData[7:0] == flash_seq_pkg::CODE_ERASECONF) state_q <= ST_NVBUSY;
            else state_q <= ST_NV;
          end
        end
        ST_NVBUSY: begin
          if (timer_q == 16'h0001) state_q <= ST_NV;
        end
        ST_PROGADDR: begin
          if (writeDone) begin
            progAddr_q <= wAddr;
            progData_q <= wData;
            state_q <= ST_PROGBUSY;
          end
        end
        ST_PROGBUSY: begin
          if (timer_q == 16'h0001) state_q <= ST_READ;
        end
        default: state_q <= ST_READ;
      endcase
    end
  end

  //--------------------------------------------------------------------
  // operation timer
  //--------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) timer_q <= 16'h0000;
    else if (writeDone && (state_q == ST_NVPROG || state_q == ST_NVERASE))
      timer_q <= 16'(NV_CYCLES);
    else if (writeDone && state_q == ST_PROGADDR) timer_q <= 16'(PROG_CYC);
    else if (timer_q != 16'h0000) timer_q <= timer_q - 16'h0001;
  end

  //--------------------------------------------------------------------
  // non-volatile bits: reset only models power-on, not persistence
  //--------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      secureBit_q <= 1'b0;
      pwLockBit_q <= 1'b0;
      persLockBit_q <= 1'b0;
      sectLock_q <= 1'b0;
      sectBits_q <= '0;
    end else if (state_q == ST_NVBUSY && timer_q == 16'h0001) begin
      if (is_sel(sel_q, flash_seq_pkg::SEL_SECURE)) begin
        if (!nvErase_q) secureBit_q <= 1'b1;
      end else if (is_sel(sel_q, flash_seq_pkg::SEL_PWLOCK)) begin
        if (!nvErase_q) pwLockBit_q <= 1'b1;
      end else if (is_sel(sel_q, flash_seq_pkg::SEL_PERSLOCK)) begin
        if (!nvErase_q) persLockBit_q <= 1'b1;
      end else if (!sectLock_q) begin
        if (nvErase_q) sectBits_q <= '0;
        else sectBits_q[nvSector_q] <= 1'b1;
      end
    end
  end

  //--------------------------------------------------------------------
  // array storage
  //--------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (state_q == ST_PROGBUSY && timer_q == 16'h0001)
      mem[progAddr_q[$clog2(WORDS)-1:0]] <= mem[progAddr_q[$clog2(WORDS)-1:0]] & progData_q;
  end
endmodule : flash_protect_bit_cmd_seq
`default_nettype wire

/* File: core/flash_seq_pkg.sv */
//----------------------------------------------------------------------
// Functional notes
//----------------------------------------------------------------------
// Functional notes
// - unlock pair then 60h enters non-volatile bit mode, no high voltage
// - in non-volatile bit mode, reads show selected bit on data line zero
// - secure-sector, password and persistent-mode lock bits are one-time settable
// - persistent sector bits program and erase; their lock gate sectLock_q is never set
// - program or erase chosen by code 68h or 60h, never address line six
// - async reads toggle the status line while a bit operation runs
// - in synchronous mode the address-valid strobe output reports bit-operation activity, not array programs
// - once toggling stops, data line zero carries the final bit value
// - bank for autoselect, bypass, erase decoded from address bits 18 and 17
// - program address latched when write and chip enable are both low
// - program data latched when the first of write or chip enable rises
// - sector selected by address bits 18 down to 11
// - array mode read returns the stored 32-bit word, no commands needed
// - F0 written anywhere returns to array read from any mode except while busy
package flash_seq_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 32;
  localparam int SECT_HI = 18;
  localparam int SECT_LO = 11;
  localparam int BANK_HI = 18;
  localparam int BANK_LO = 17;
  localparam logic [10:0] UNLOCK_ADDR1 = 11'h555;
  localparam logic [10:0] UNLOCK_ADDR2 = 11'h2AA;
  localparam logic [7:0] CODE_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
  localparam logic [7:0] CODE_NVMODE = 8'h60;
  localparam logic [7:0] CODE_NVPROG = 8'h68;
  localparam logic [7:0] CODE_NVERASE = 8'h60;
  localparam logic [7:0] CODE_PROGCONF = 8'h48;
  localparam logic [7:0] CODE_ERASECONF = 8'h40;
  localparam logic [7:0] CODE_PROGRAM = 8'hA0;
  localparam logic [7:0] CODE_RESET = 8'hF0;
  // low address selectors for the lock bits, bit 2 don't care
  localparam logic [5:0] SEL_MASK = 6'h3B;
  localparam logic [5:0] SEL_SECURE = 6'h1A;
  localparam logic [5:0] SEL_PWLOCK = 6'h0A;
  localparam logic [5:0] SEL_PERSLOCK = 6'h12;
  localparam logic [5:0] SEL_SECTBIT = 6'h3A;
  localparam int NV_OP_NS = 1000;
  localparam int CLK_NS = 10;
  localparam int NV_OP_CYCLES = (NV_OP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROG_NS = 500;
  localparam int PROG_CYCLES = (PROG_NS + CLK_NS - 1) / CLK_NS;
  localparam int NUM_SECTORS = 256;
endpackage : flash_seq_pkg

/* File: core/bus_cycle_latch.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_cycle_latch #(
  parameter int AW = flash_seq_pkg::ADDR_W,
  parameter int DW = flash_seq_pkg::DATA_W
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic chipEnable_n,
  input wire logic writeEnable_n,
  input wire logic [AW-1:0] addrIn,
  input wire logic [DW-1:0] dataIn,
  output logic writeDone,
  output logic [AW-1:0] latchAddr_q,
  output logic [DW-1:0] latchData_q
);
  logic active;
  logic activeDly_q;
  assign active = !chipEnable_n && !writeEnable_n;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) activeDly_q <= 1'b0;
    else activeDly_q <= active;
  end
  // address at the later falling edge: both enables now low
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) latchAddr_q <= '0;
    else if (active && !activeDly_q) latchAddr_q <= addrIn;
  end
  // data at the first rising edge: either enable goes high
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) latchData_q <= '0;
    else if (active) latchData_q <= dataIn;
  end
  assign writeDone = activeDly_q && !active;
endmodule : bus_cycle_latch
`default_nettype wire

/* File: core/read_status_mux.sv */
`timescale 1ns/1ps
`default_nettype none
module read_status_mux #(
  parameter int DW = flash_seq_pkg::DATA_W
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic readStrobe,
  input wire logic nvMode,
  input wire logic nvBusy,
  input wire logic nvBitValue,
  input wire logic [DW-1:0] arrayWord,
  output logic [DW-1:0] readData_q
);
  logic toggle_q;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) toggle_q <= 1'b0;
    else if (readStrobe && nvBusy) toggle_q <= !toggle_q;
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) readData_q <= '0;
    else if (readStrobe) begin
      if (nvBusy) readData_q <= {{(DW-7){1'b0}}, !toggle_q, 6'h00};
      else if (nvMode) readData_q <= {{(DW-1){1'b0}}, nvBitValue};
      else readData_q <= arrayWord;
    end
  end
endmodule : read_status_mux
`default_nettype wire

/* File: tb/flash_seq_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_seq_checker (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic chipEnable_n,
  input wire logic writeEnable_n,
  input wire logic outputEnable_n,
  input wire logic syncMode,
  input wire logic [18:0] addrIn,
  input wire logic [31:0] dataIn,
  input wire logic [31:0] readData_q,
  input wire logic address_valid_n,
  input wire logic [1:0] bank_q,
  input wire logic [7:0] sector_address_q,
  input wire logic nvMode,
  input wire logic busy
);
  // ----------------------------------------
  // port relations
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sync_off_a: assert property (!syncMode |-> address_valid_n)
    else $error("strobe low in async mode");
  sync_busy_a: assert property (!address_valid_n |-> busy && nvMode)
    else $error("strobe low while idle");
  sync_on_a: assert property (syncMode && busy && nvMode |-> !address_valid_n)
    else $error("strobe high during bit op");
  bank_sect_a: assert property (bank_q == sector_address_q[7:6])
    else $error("bank and sector disagree");
  // address is held after release, so it is still the written one here
  sector_cap_a: assert property ($rose(writeEnable_n) && $past(chipEnable_n) == 1'b0
    |-> ##[1:3] sector_address_q == addrIn[18:11]) else $error("sector not captured");
  bank_cap_a: assert property ($rose(writeEnable_n) && $past(chipEnable_n) == 1'b0
    |-> ##[1:3] bank_q == addrIn[18:17]) else $error("bank not captured");
  rd_hold_a: assert property ($changed(readData_q)
    |-> $past(chipEnable_n) == 1'b0 && $past(outputEnable_n) == 1'b0)
    else $error("read data moved without strobe");
  reset_exit_a: assert property ($rose(writeEnable_n) && $past(dataIn[7:0]) == 8'hF0
    && $past(chipEnable_n) == 1'b0 && !busy |-> ##[1:3] !nvMode)
    else $error("reset code did not leave bit mode");
  cover property ($rose(busy) && nvMode);
  cover property (!address_valid_n);
  cover property ($fell(nvMode));
endmodule : flash_seq_checker
bind flash_protect_bit_cmd_seq flash_seq_checker chk_i (.sys_clk(sys_clk), .reset_n(reset_n),
  .chipEnable_n(chipEnable_n), .writeEnable_n(writeEnable_n),
  .outputEnable_n(outputEnable_n), .syncMode(syncMode), .addrIn(addrIn), .dataIn(dataIn),
  .readData_q(readData_q), .address_valid_n(address_valid_n), .bank_q(bank_q),
  .sector_address_q(sector_address_q), .nvMode(nvMode), .busy(busy));
`default_nettype wire

/* File: tb/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic sys_clk,
  input wire logic busy,
  input wire logic [31:0] readData_q,
  output logic chipEnable_n,
  output logic writeEnable_n,
  output logic outputEnable_n,
  output logic [18:0] addrIn,
  output logic [31:0] dataIn
);
  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  initial begin
    chipEnable_n = 1'b1;
    writeEnable_n = 1'b1;
    outputEnable_n = 1'b1;
    addrIn = 19'h0_0000;
    dataIn = 32'h0000_0000;
  end
  function automatic logic [31:0] cw(input logic [7:0] c);
    return {24'h00_0000, c};
  endfunction : cw
  task automatic wr(input logic [18:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addrIn <= a;
    dataIn <= d;
    chipEnable_n <= 1'b0;
    writeEnable_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chipEnable_n <= 1'b1;
    writeEnable_n <= 1'b1;
    // released data lines show the inverse, never the last value
    dataIn <= ~d;
    repeat (4) @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [18:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    addrIn <= a;
    chipEnable_n <= 1'b0;
    outputEnable_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    v = readData_q;
    chipEnable_n <= 1'b1;
    outputEnable_n <= 1'b1;
  endtask : rd
  task automatic idle();
    @(negedge sys_clk);
    // no local limit: a stuck busy runs into the bench watchdog
    while (busy !== 1'b0) @(negedge sys_clk);
  endtask : idle
  task automatic unl(input logic [7:0] c);
    wr(19'(flash_seq_pkg::UNLOCK_ADDR1), cw(flash_seq_pkg::CODE_UNLOCK1));
    wr(19'(flash_seq_pkg::UNLOCK_ADDR2), cw(flash_seq_pkg::CODE_UNLOCK2));
    wr(19'(flash_seq_pkg::UNLOCK_ADDR1), cw(c));
  endtask : unl
  task automatic nvOp(input logic [18:0] a, input logic [7:0] code, input logic [7:0] conf,
                      input logic want, output logic b);
    logic [31:0] v;
    b = ~want;
    // retries bounded so a stuck bit cannot hang the run
    for (int t = 0; t < 3 && b !== want; t++) begin
      idle();
      wr(19'h0_0000, cw(flash_seq_pkg::CODE_RESET));
      unl(flash_seq_pkg::CODE_NVMODE);
      wr(a, cw(code));
      wr(a, cw(conf));
      idle();
      rd(a, v);
      b = v[0];
    end
  endtask : nvOp
endmodule : host_model
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic syncMode = 1'b0;
  logic chipEnable_n, writeEnable_n, outputEnable_n, address_valid_n, nvMode, busy;
  logic [18:0] addrIn;
  logic [31:0] dataIn, readData_q;
  logic [1:0] bank_q;
  logic [7:0] sector_address_q;
  int failures = 0;
  int checks_done = 0;
  localparam logic [18:0] PROG_ADDR = 19'h5_A812;
  always #5 sys_clk = ~sys_clk;
  // short bit-op time keeps toggle reads inside the busy window
  flash_protect_bit_cmd_seq #(.NV_CYCLES(30), .PROG_CYC(8)) uut (.sys_clk(sys_clk),
    .reset_n(reset_n), .chipEnable_n(chipEnable_n), .writeEnable_n(writeEnable_n),
    .outputEnable_n(outputEnable_n), .syncMode(syncMode), .addrIn(addrIn), .dataIn(dataIn),
    .readData_q(readData_q), .address_valid_n(address_valid_n), .bank_q(bank_q),
    .sector_address_q(sector_address_q), .nvMode(nvMode), .busy(busy));
  host_model host (.sys_clk(sys_clk), .busy(busy), .readData_q(readData_q),
    .chipEnable_n(chipEnable_n), .writeEnable_n(writeEnable_n),
    .outputEnable_n(outputEnable_n), .addrIn(addrIn), .dataIn(dataIn));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic final_report();
    $display("failures %0d checks_done %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  initial begin
    #200000;
    failures++;
    final_report();
  end
  initial begin : tests
    logic [31:0] v, w;
    logic b;
    logic [5:0] sels [3];
    sels = '{flash_seq_pkg::SEL_SECURE, flash_seq_pkg::SEL_PWLOCK, flash_seq_pkg::SEL_PERSLOCK};
    repeat (3) @(posedge sys_clk);
    chk("busy", 32'(busy), 32'h0000_0000);
    chk("strobe", 32'(address_valid_n), 32'h0000_0001);
    chk("rdata", readData_q, 32'h0000_0000);
    reset_n <= 1'b1;
    host.unl(flash_seq_pkg::CODE_PROGRAM);
    host.wr(PROG_ADDR, 32'h0000_0000);
    chk("busy", 32'(busy), 32'h0000_0001);
    chk("bank", 32'(bank_q), 32'(PROG_ADDR[18:17]));
    chk("sector", 32'(sector_address_q), 32'(PROG_ADDR[18:11]));
    host.idle();
    host.rd(PROG_ADDR, v);
    chk("word", v, 32'h0000_0000);
    host.wr(19'h0_0000, host.cw(flash_seq_pkg::CODE_RESET));
    host.unl(flash_seq_pkg::CODE_NVMODE);
    chk("mode", 32'(nvMode), 32'h0000_0001);
    host.wr(19'h1_087A, host.cw(flash_seq_pkg::CODE_NVPROG));
    host.wr(19'h1_087A, host.cw(flash_seq_pkg::CODE_PROGCONF));
    host.rd(19'h1_087A, v);
    host.rd(19'h1_087A, w);
    chk("toggle", 32'(v[6] ^ w[6]), 32'h0000_0001);
    syncMode <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("strobe", 32'(address_valid_n), 32'h0000_0000);
    host.idle();
    chk("strobe", 32'(address_valid_n), 32'h0000_0001);
    @(posedge sys_clk);
    syncMode <= 1'b0;
    host.rd(19'h1_087A, v);
    chk("sector bit", 32'(v[0]), 32'h0000_0001);
    host.nvOp(19'h1_083A, flash_seq_pkg::CODE_NVERASE, flash_seq_pkg::CODE_ERASECONF, 1'b0, b);
    chk("sector bit", 32'(b), 32'h0000_0000);
    foreach (sels[i]) begin
      host.nvOp({13'h0000, sels[i]}, flash_seq_pkg::CODE_NVPROG,
                flash_seq_pkg::CODE_PROGCONF, 1'b1, b);
      chk("lock set", 32'(b), 32'h0000_0001);
      host.nvOp({13'h0000, sels[i]}, flash_seq_pkg::CODE_NVERASE,
                flash_seq_pkg::CODE_ERASECONF, 1'b0, b);
      chk("lock kept", 32'(b), 32'h0000_0001);
    end
    host.wr(19'h0_0000, host.cw(flash_seq_pkg::CODE_RESET));
    chk("mode", 32'(nvMode), 32'h0000_0000);
    host.rd(PROG_ADDR, v);
    chk("word", v, 32'h0000_0000);
    final_report();
  end
endmodule : testbench
`default_nettype wire
